// File: hw/scan_chain_pkg.sv
// Constants, cell positions and register map of the boundary-scan chain.
package scan_chain_pkg;
	localparam int CHAIN_LEN = 198;
	localparam int PINS = 8;
	localparam int CELLS_PER_PIN = 3;
	localparam int POS_COMP_IDLE = 197;
	localparam int POS_COMP_OUT = 196;
	localparam int POS_COMP_MUX = 195;
	localparam int POS_COMP_BG = 194;
	localparam int POS_COMP_RESULT = 193;
	localparam int POS_CONV_CLK = 192;
	localparam int POS_ATEST = 191;
	localparam int POS_UNDISC = 190;
	localparam int POS_CONV_BG = 189;
	localparam int POS_CONV_EN = 188;
	localparam int POS_AMP_EN = 187;
	localparam int POS_CODE_MSB = 186;
	localparam int POS_CODE_LSB = 177;
	localparam int POS_EXT_CH = 176;
	localparam int POS_GND = 175;
	localparam int POS_HOLD = 174;
	localparam int POS_IREF = 173;
	localparam int POS_MUX_MSB = 172;
	localparam int POS_MUX_LSB = 165;
	localparam int POS_NEG_MSB = 164;
	localparam int POS_NEG_LSB = 162;
	localparam int POS_PASS = 161;
	localparam int POS_LATCH_PRECHARGE_N = 160;
	localparam int POS_SETTLE = 159;
	localparam int POS_VCCREF = 158;
	localparam int POS_PORT_E_TOP = 157;
	localparam int POS_PB0_DATA = 133;
	localparam int POS_PORT_A_BOTTOM = 14;
	localparam int POS_OTHER_TOP = 130;
	localparam int OTHER_CELLS = 131;
	localparam int SNAP_WORDS = 7;
	localparam int SNAP_BITS = 224;
	localparam int AXI_ADDR_W = 12;
	localparam logic [AXI_ADDR_W-1:0] ADDR_CTRL = 12'h000;
	localparam logic [AXI_ADDR_W-1:0] ADDR_STATUS = 12'h004;
	localparam logic [AXI_ADDR_W-1:0] ADDR_SNAP_BASE = 12'h010;
	localparam logic [AXI_ADDR_W-1:0] ADDR_SNAP_END = 12'h02c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic CTRL_DRIVE_RESET = 1'h0;
	localparam logic [15:0] SNAP_COUNT_RESET = 16'h0000;
	typedef logic [CHAIN_LEN-1:0] cells_t;
	typedef logic [SNAP_BITS-1:0] snap_t;
	localparam cells_t SAFE_CELLS = (cells_t'(1) << POS_MUX_LSB) | (cells_t'(1) << POS_PASS)
		| (cells_t'(1) << POS_LATCH_PRECHARGE_N);

	function automatic int port_e_data_pos(input int pin);
		return POS_PORT_E_TOP - CELLS_PER_PIN * pin;
	endfunction

	function automatic int port_a_data_pos(input int pin);
		return POS_PORT_A_BOTTOM + CELLS_PER_PIN * pin;
	endfunction
endpackage

// File: hw/sync2.sv
// Two-flop level synchroniser with a synchronous clear.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         clear,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk)
	begin
		if (clear)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// File: hw/word_handshake.sv
// Toggle request and acknowledge handshake that moves one word between clocks.
`timescale 1ns/1ps
`default_nettype none
module word_handshake #(
	parameter int W = 8
) (
	input  wire logic         src_clk,
	input  wire logic         src_clear,
	input  wire logic         src_load,
	input  wire logic [W-1:0] src_data,
	output logic              src_busy,
	input  wire logic         dst_clk,
	input  wire logic         dst_clear,
	output logic      [W-1:0] dst_data,
	output logic              dst_strobe
);
	logic [W-1:0] hold_q;
	logic         req_q;
	logic         ack_q;
	logic         req_s;
	logic         ack_s;

	sync2 #(.W(1)) u_req_sync (.clk(dst_clk), .clear(dst_clear), .d(req_q), .q(req_s));
	sync2 #(.W(1)) u_ack_sync (.clk(src_clk), .clear(src_clear), .d(ack_q), .q(ack_s));

	assign src_busy = req_q ^ ack_s;

	// The held word stays still until the far side has acknowledged it.
	always_ff @(posedge src_clk)
	begin
		if (src_clear)
		begin
			hold_q <= '0;
			req_q <= 1'b0;
		end
		else if (src_load && !src_busy)
		begin
			hold_q <= src_data;
			req_q <= ~req_q;
		end
	end

	always_ff @(posedge dst_clk)
	begin
		if (dst_clear)
		begin
			dst_data <= '0;
			ack_q <= 1'b0;
			dst_strobe <= 1'b0;
		end
		else
		begin
			dst_strobe <= req_s ^ ack_q;
			if (req_s ^ ack_q)
			begin
				dst_data <= hold_q;
				ack_q <= req_s;
			end
		end
	end
endmodule
`default_nettype wire

// File: hw/boundary_scan_chain.sv
// Boundary-scan register with its fixed cell order and an AXI4-Lite view.
// What this block does
// - The top cell is first in and cell zero is first out
// - Port A cells run in reversed pin order
// - Analog cells sit at the top end
// - Each pin has data, direction, pull-up cells
// - Port F pins 4 to 7 have no cells
// - Comparator 197-193, converter 192-158, fixed positions
// - Port E at 157-134, then PB0 data 133
// - Precharge cell is active low
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_chain (
	input  wire logic                                   aclk,
	input  wire logic                                   aresetn,
	input  wire logic [scan_chain_pkg::AXI_ADDR_W-1:0]  awaddr,
	input  wire logic                                   awvalid,
	output logic                                        awready,
	input  wire logic [31:0]                            wdata,
	input  wire logic [3:0]                             wstrb,
	input  wire logic                                   wvalid,
	output logic                                        wready,
	output logic      [1:0]                             bresp,
	output logic                                        bvalid,
	input  wire logic                                   bready,
	input  wire logic [scan_chain_pkg::AXI_ADDR_W-1:0]  araddr,
	input  wire logic                                   arvalid,
	output logic                                        arready,
	output logic      [31:0]                            rdata,
	output logic      [1:0]                             rresp,
	output logic                                        rvalid,
	input  wire logic                                   rready,
	input  wire logic                                   test_clk,
	input  wire logic                                   tap_reset,
	input  wire logic                                   tdi,
	output wire logic                                   tdo,
	input  wire logic                                   capture_dr,
	input  wire logic                                   shift_dr,
	input  wire logic                                   update_dr,
	input  wire logic                                   extest_active,
	input  wire logic                                   comparator_result,
	output wire logic                                   comparator_idle_cell,
	output wire logic                                   comparator_output_cell,
	output wire logic                                   comparator_mux_enable,
	output wire logic                                   comparator_bandgap_select,
	output wire logic                                   conv_clock_cell,
	output wire logic                                   analog_test_enable,
	output wire logic                                   undisclosed_cell,
	output wire logic                                   conv_bandgap_enable,
	output wire logic                                   converter_enable_cell,
	output wire logic                                   diff_amp_enable,
	output wire logic [9:0]                             conv_code,
	output wire logic                                   external_channel_cell,
	output wire logic                                   ground_path_enable,
	output wire logic                                   conv_hold,
	output wire logic                                   internal_ref_enable,
	output wire logic [7:0]                             channel_select_bits,
	output wire logic [2:0]                             negative_input_select,
	output wire logic                                   amp_passgate_enable,
	output wire logic                                   latch_precharge_n,
	output wire logic                                   amp_fast_settle,
	output wire logic                                   supply_ref_select,
	input  wire logic [7:0]                             port_e_in,
	output logic      [7:0]                             port_e_out,
	output logic      [7:0]                             port_e_oe,
	output logic      [7:0]                             port_e_pullup,
	input  wire logic [7:0]                             port_a_in,
	output logic      [7:0]                             port_a_out,
	output logic      [7:0]                             port_a_oe,
	output logic      [7:0]                             port_a_pullup,
	input  wire logic                                   pb0_in,
	output wire logic                                   pb0_out,
	output wire logic                                   pb0_oe,
	output wire logic                                   pb0_pullup,
	input  wire logic [scan_chain_pkg::OTHER_CELLS-1:0] other_cells_capture,
	output wire logic [scan_chain_pkg::OTHER_CELLS-1:0] other_cells_update
);
	scan_chain_pkg::cells_t chain_q;
	scan_chain_pkg::cells_t upd_q;
	scan_chain_pkg::cells_t view_q;
	scan_chain_pkg::cells_t cap_vec;
	scan_chain_pkg::cells_t snap_data;
	scan_chain_pkg::snap_t  snap_pad;
	logic [17:0]            pin_s;
	logic [7:0]             port_e_s;
	logic [7:0]             port_a_s;
	logic                   pb0_s;
	logic                   comp_s;
	logic                   drive_en_s;
	logic                   test_on;
	logic                   upd_load_q;
	logic                   snap_strobe;
	logic                   drive_en_q;
	logic [15:0]            snap_count_q;
	logic                   aw_held_q;
	logic                   w_held_q;
	logic [scan_chain_pkg::AXI_ADDR_W-1:0] awaddr_q;
	logic [31:0]            wdata_q;
	logic [3:0]             wstrb_q;
	logic [31:0]            rd_word;
	logic [1:0]             rd_resp;
	logic [2:0]             snap_idx;

	// Pin levels and the comparator come from outside this clock.
	sync2 #(.W(18)) u_pin_sync (
		.clk   (test_clk),
		.clear (tap_reset),
		.d     ({comparator_result, pb0_in, port_a_in, port_e_in}),
		.q     (pin_s)
	);

	sync2 #(.W(1)) u_drive_sync (
		.clk   (test_clk),
		.clear (tap_reset),
		.d     (drive_en_q),
		.q     (drive_en_s)
	);

	assign port_e_s = pin_s[7:0];
	assign port_a_s = pin_s[15:8];
	assign pb0_s = pin_s[16];
	assign comp_s = pin_s[17];
	assign test_on = extest_active && drive_en_s;

	// Captured values: pin levels in data cells, the comparator result, other_cells_capture in the other cells 130 to 0, and held values elsewhere.
	always_comb
	begin
		cap_vec = upd_q;
		cap_vec[scan_chain_pkg::POS_OTHER_TOP:0] = other_cells_capture;
		cap_vec[scan_chain_pkg::POS_COMP_RESULT] = comp_s;
		cap_vec[scan_chain_pkg::POS_PB0_DATA] = pb0_s;
		// Port F upper pins have no cells at all; they serve as the test port.
		for (int i = 0; i < scan_chain_pkg::PINS; i++)
		begin
			cap_vec[scan_chain_pkg::port_e_data_pos(i)] = port_e_s[i];
			cap_vec[scan_chain_pkg::port_a_data_pos(i)] = port_a_s[i];
		end
	end

	// One shift path: in at the top cell, out from cell zero.
	always_ff @(posedge test_clk)
	begin
		if (tap_reset)
			chain_q <= '0;
		else if (capture_dr)
			chain_q <= cap_vec;
		else if (shift_dr)
			chain_q <= {tdi, chain_q[scan_chain_pkg::CHAIN_LEN-1:1]};
	end

	assign tdo = chain_q[0];

	// The update stage starts from the safe analog settings.
	always_ff @(posedge test_clk)
	begin
		if (tap_reset)
			upd_q <= scan_chain_pkg::SAFE_CELLS;
		else if (update_dr)
			upd_q <= chain_q;
	end

	// Outside an enabled external test the pins are released and analog cells stay safe.
	always_ff @(posedge test_clk)
	begin
		if (tap_reset)
			view_q <= scan_chain_pkg::SAFE_CELLS;
		else if (test_on)
			view_q <= upd_q;
		else
			view_q <= scan_chain_pkg::SAFE_CELLS;
	end

	always_ff @(posedge test_clk)
	begin
		if (tap_reset)
			upd_load_q <= 1'b0;
		else
			upd_load_q <= update_dr;
	end

	// Analog cells occupy the top of the chain.
	assign comparator_idle_cell = view_q[scan_chain_pkg::POS_COMP_IDLE];
	assign comparator_output_cell = view_q[scan_chain_pkg::POS_COMP_OUT];
	assign comparator_mux_enable = view_q[scan_chain_pkg::POS_COMP_MUX];
	assign comparator_bandgap_select = view_q[scan_chain_pkg::POS_COMP_BG];
	assign conv_clock_cell = view_q[scan_chain_pkg::POS_CONV_CLK];
	assign analog_test_enable = view_q[scan_chain_pkg::POS_ATEST];
	assign undisclosed_cell = view_q[scan_chain_pkg::POS_UNDISC];
	assign conv_bandgap_enable = view_q[scan_chain_pkg::POS_CONV_BG];
	assign converter_enable_cell = view_q[scan_chain_pkg::POS_CONV_EN];
	assign diff_amp_enable = view_q[scan_chain_pkg::POS_AMP_EN];
	assign conv_code = view_q[scan_chain_pkg::POS_CODE_MSB:scan_chain_pkg::POS_CODE_LSB];
	assign external_channel_cell = view_q[scan_chain_pkg::POS_EXT_CH];
	assign ground_path_enable = view_q[scan_chain_pkg::POS_GND];
	assign conv_hold = view_q[scan_chain_pkg::POS_HOLD];
	assign internal_ref_enable = view_q[scan_chain_pkg::POS_IREF];
	assign channel_select_bits = view_q[scan_chain_pkg::POS_MUX_MSB:scan_chain_pkg::POS_MUX_LSB];
	assign negative_input_select = view_q[scan_chain_pkg::POS_NEG_MSB:scan_chain_pkg::POS_NEG_LSB];
	assign amp_passgate_enable = view_q[scan_chain_pkg::POS_PASS];
	assign latch_precharge_n = view_q[scan_chain_pkg::POS_LATCH_PRECHARGE_N];
	assign amp_fast_settle = view_q[scan_chain_pkg::POS_SETTLE];
	assign supply_ref_select = view_q[scan_chain_pkg::POS_VCCREF];
	assign pb0_out = view_q[scan_chain_pkg::POS_PB0_DATA];
	assign pb0_oe = view_q[scan_chain_pkg::POS_PB0_DATA-1];
	assign pb0_pullup = view_q[scan_chain_pkg::POS_PB0_DATA-2];
	assign other_cells_update = view_q[scan_chain_pkg::POS_OTHER_TOP:0];

	// Each pin takes data, direction and pull-up cells in descending order.
	always_comb
	begin
		for (int i = 0; i < scan_chain_pkg::PINS; i++)
		begin
			port_e_out[i] = view_q[scan_chain_pkg::port_e_data_pos(i)];
			port_e_oe[i] = view_q[scan_chain_pkg::port_e_data_pos(i)-1];
			port_e_pullup[i] = view_q[scan_chain_pkg::port_e_data_pos(i)-2];
			port_a_out[i] = view_q[scan_chain_pkg::port_a_data_pos(i)];
			port_a_oe[i] = view_q[scan_chain_pkg::port_a_data_pos(i)-1];
			port_a_pullup[i] = view_q[scan_chain_pkg::port_a_data_pos(i)-2];
		end
	end

	// Each update is offered to the bus side; one arriving while busy is skipped.
	word_handshake #(.W(scan_chain_pkg::CHAIN_LEN)) u_snap (
		.src_clk    (test_clk),
		.src_clear  (tap_reset),
		.src_load   (upd_load_q),
		.src_data   (upd_q),
		.src_busy   (),
		.dst_clk    (aclk),
		.dst_clear  (!aresetn),
		.dst_data   (snap_data),
		.dst_strobe (snap_strobe)
	);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			snap_count_q <= scan_chain_pkg::SNAP_COUNT_RESET;
		else if (snap_strobe)
			snap_count_q <= snap_count_q + 16'h0001;
	end

	assign awready = !aw_held_q && !bvalid;
	assign wready = !w_held_q && !bvalid;
	assign arready = !rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			awaddr_q <= '0;
		end
		else if (awvalid && awready)
		begin
			aw_held_q <= 1'b1;
			awaddr_q <= awaddr;
		end
		else if (aw_held_q && w_held_q)
			aw_held_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_q <= 1'b0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else if (wvalid && wready)
		begin
			w_held_q <= 1'b1;
			wdata_q <= wdata;
			wstrb_q <= wstrb;
		end
		else if (aw_held_q && w_held_q)
			w_held_q <= 1'b0;
	end

	// The control word gates pin driving during external test.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			drive_en_q <= scan_chain_pkg::CTRL_DRIVE_RESET;
		else if (aw_held_q && w_held_q && awaddr_q == scan_chain_pkg::ADDR_CTRL && wstrb_q[0])
			drive_en_q <= wdata_q[0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid <= 1'b0;
			bresp <= scan_chain_pkg::RESP_OKAY;
		end
		else if (aw_held_q && w_held_q)
		begin
			bvalid <= 1'b1;
			bresp <= (awaddr_q == scan_chain_pkg::ADDR_CTRL) ? scan_chain_pkg::RESP_OKAY
				: scan_chain_pkg::RESP_SLVERR;
		end
		else if (bready)
			bvalid <= 1'b0;
	end

	assign snap_pad = scan_chain_pkg::snap_t'(snap_data);
	assign snap_idx = 3'((araddr - scan_chain_pkg::ADDR_SNAP_BASE) >> 2);

	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_resp = scan_chain_pkg::RESP_OKAY;
		if (araddr == scan_chain_pkg::ADDR_CTRL)
			rd_word = {31'h0000_0000, drive_en_q};
		else if (araddr == scan_chain_pkg::ADDR_STATUS)
			rd_word = {16'h0000, snap_count_q};
		else if (araddr >= scan_chain_pkg::ADDR_SNAP_BASE && araddr < scan_chain_pkg::ADDR_SNAP_END)
			rd_word = snap_pad[snap_idx*32 +: 32];
		else
			rd_resp = scan_chain_pkg::RESP_SLVERR;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= scan_chain_pkg::RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= rd_resp;
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	a_tdo_lsb_out: assert property (@(posedge test_clk) disable iff (tap_reset)
		shift_dr && !capture_dr |=> tdo == $past(chain_q[1]))
		else $error("Cell one did not move to the output.");

	a_tdi_top_in: assert property (@(posedge test_clk) disable iff (tap_reset)
		shift_dr && !capture_dr |=> chain_q[scan_chain_pkg::CHAIN_LEN-1] == $past(tdi))
		else $error("Input bit did not enter the top cell.");

	a_comp_result_capture: assert property (@(posedge test_clk) disable iff (tap_reset)
		capture_dr |=> chain_q[scan_chain_pkg::POS_COMP_RESULT] == $past(comp_s))
		else $error("Comparator result not captured in its cell.");

	a_code_hold_cells: assert property (@(posedge test_clk) disable iff (tap_reset)
		test_on |=> conv_code == $past(upd_q[scan_chain_pkg::POS_CODE_MSB:scan_chain_pkg::POS_CODE_LSB])
			&& conv_hold == $past(upd_q[scan_chain_pkg::POS_HOLD]))
		else $error("Converter code or hold cell misplaced.");

	a_port_e_cells: assert property (@(posedge test_clk) disable iff (tap_reset)
		test_on |=> port_e_out[0] == $past(upd_q[scan_chain_pkg::POS_PORT_E_TOP])
			&& port_e_oe[7] == $past(upd_q[scan_chain_pkg::POS_PB0_DATA+2])
			&& port_e_pullup[7] == $past(upd_q[scan_chain_pkg::POS_PB0_DATA+1]))
		else $error("Port E cells out of place.");

	a_port_a_reversed: assert property (@(posedge test_clk) disable iff (tap_reset)
		test_on |=> port_a_out[0] == $past(upd_q[scan_chain_pkg::POS_PORT_A_BOTTOM])
			&& port_a_out[7] == $past(upd_q[scan_chain_pkg::POS_PORT_A_BOTTOM+21]))
		else $error("Port A cells not in reversed order.");

	a_pb0_triplet: assert property (@(posedge test_clk) disable iff (tap_reset)
		test_on |=> pb0_out == $past(upd_q[scan_chain_pkg::POS_PB0_DATA])
			&& pb0_oe == $past(upd_q[scan_chain_pkg::POS_PB0_DATA-1])
			&& pb0_pullup == $past(upd_q[scan_chain_pkg::POS_PB0_DATA-2]))
		else $error("Pin cell triplet out of order.");

	a_precharge_idle_high: assert property (@(posedge test_clk) disable iff (tap_reset)
		!test_on |=> latch_precharge_n && port_e_oe == 8'h00 && !pb0_oe)
		else $error("Precharge or pin drive active outside test.");
endmodule
`default_nettype wire

// File: tb/scan_tester.sv
// Tester model that clocks the scan chain through capture, shift and update.
`timescale 1ns/1ps
`default_nettype none
module scan_tester (
	output logic      test_clk,
	output logic      tap_reset,
	output logic      tdi,
	output logic      capture_dr,
	output logic      shift_dr,
	output logic      update_dr,
	output logic      extest_active,
	input  wire logic tdo
);
	scan_chain_pkg::cells_t dout;
	event                   done;
	initial
	begin
		{test_clk, tdi, capture_dr, shift_dr, update_dr, extest_active} = 6'h00;
		tap_reset = 1'h1;
	end
	// The clock stands still between frames and an unshifted tdi keeps toggling.
	task automatic tick(input int n);
		repeat (n)
		begin
			#3 test_clk = 1'h1;
			#3 test_clk = 1'h0;
			if (!shift_dr)
				tdi = ~tdi;
		end
	endtask
	task automatic reset_chain();
		tap_reset = 1'h1;
		tick(3);
		tap_reset = 1'h0;
		// Two more edges fill the pin synchronisers before the first capture.
		tick(2);
	endtask
	task automatic scan(input scan_chain_pkg::cells_t din, input logic ext);
		extest_active = ext;
		capture_dr = 1'h1;
		tick(1);
		capture_dr = 1'h0;
		shift_dr = 1'h1;
		for (int i = 0; i < scan_chain_pkg::CHAIN_LEN; i++)
		begin
			tdi = din[i];
			dout[i] = tdo;
			tick(1);
		end
		shift_dr = 1'h0;
		update_dr = 1'h1;
		tick(1);
		update_dr = 1'h0;
		tick(6);
		->done;
	endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the boundary-scan chain and its register view.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef scan_chain_pkg::cells_t chain_t;
	logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, comparator_result, pb0_in;
	logic         awready, wready, bvalid, arready, rvalid, tdo, test_clk, tap_reset, tdi, cap, sh, upd, ext;
	logic         conv_hold, latch_precharge_n;
	logic [1:0]   bresp, rresp;
	logic [3:0]   wstrb;
	logic [7:0]   port_e_in, port_a_in, port_e_out, port_e_oe, port_e_pullup, port_a_out, port_a_oe, port_a_pullup;
	logic [7:0]   channel_select_bits;
	logic [9:0]   conv_code;
	logic [11:0]  awaddr, araddr;
	logic [31:0]  wdata, rdata;
	logic [130:0] occ;
	logic [395:0] sq[$];
	logic [67:0]  pq[$];
	logic [33:0]  rq[$];
	logic [1:0]   bq[$];
	int           n_fail = 0;
	int           compares = 0;
	int           cyc = 0;
	integer       seed = 32'he278;
	chain_t       va, vb;
	scan_tester tst (.test_clk(test_clk), .tap_reset(tap_reset), .tdi(tdi), .capture_dr(cap), .shift_dr(sh),
		.update_dr(upd), .extest_active(ext), .tdo(tdo));
	boundary_scan_chain u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .test_clk(test_clk), .tap_reset(tap_reset), .tdi(tdi), .tdo(tdo), .capture_dr(cap),
		.shift_dr(sh), .update_dr(upd), .extest_active(ext), .comparator_result(comparator_result),
		.comparator_idle_cell(), .comparator_output_cell(), .comparator_mux_enable(), .comparator_bandgap_select(),
		.conv_clock_cell(), .analog_test_enable(), .undisclosed_cell(), .conv_bandgap_enable(),
		.converter_enable_cell(), .diff_amp_enable(), .conv_code(conv_code), .external_channel_cell(),
		.ground_path_enable(), .conv_hold(conv_hold), .internal_ref_enable(), .channel_select_bits(channel_select_bits),
		.negative_input_select(), .amp_passgate_enable(), .latch_precharge_n(latch_precharge_n), .amp_fast_settle(),
		.supply_ref_select(), .port_e_in(port_e_in), .port_e_out(port_e_out), .port_e_oe(port_e_oe),
		.port_e_pullup(port_e_pullup), .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
		.port_a_pullup(port_a_pullup), .pb0_in(pb0_in), .pb0_out(), .pb0_oe(), .pb0_pullup(),
		.other_cells_capture(occ), .other_cells_update());
	initial
	begin
		aclk = 1'h0;
		forever #25 aclk = ~aclk;
	end
	// The analog input sits between the two limit codes.
	always @(posedge test_clk)
		if (latch_precharge_n === 1'h0)
			comparator_result <= conv_code > 10'h133;
	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			tally_and_finish();
		end
		if (bvalid && bready)
			check(bresp, bq.pop_front());
		if (rvalid && rready)
			check({rresp, rdata}, rq.pop_front());
	end
	always @(tst.done)
	begin
		check(tst.dout & sq[0][395:198], sq[0][197:0]);
		check({port_e_out, port_e_oe, port_e_pullup, port_a_out, port_a_oe, port_a_pullup, conv_code, conv_hold,
			latch_precharge_n, channel_select_bits}, pq.pop_front());
		void'(sq.pop_front());
	end
	function automatic chain_t rnd();
		return chain_t'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
			$random(seed)});
	endfunction
	function automatic chain_t cap_of(input chain_t u);
		chain_t c = u;
		c[130:0] = occ;
		for (int n = 0; n < 8; n++)
		begin
			c[157 - 3 * n] = port_e_in[n];
			c[14 + 3 * n] = port_a_in[n];
		end
		c[133] = pb0_in;
		c[193] = comparator_result;
		return c;
	endfunction
	function automatic logic [67:0] pins(input chain_t v);
		logic [7:0] eo, ee, ep, ao, ae, ap;
		for (int n = 0; n < 8; n++)
		begin
			{eo[n], ee[n], ep[n]} = {v[157 - 3 * n], v[156 - 3 * n], v[155 - 3 * n]};
			{ao[n], ae[n], ap[n]} = {v[14 + 3 * n], v[13 + 3 * n], v[12 + 3 * n]};
		end
		return {eo, ee, ep, ao, ae, ap, v[186:177], v[174], v[160], v[172:165]};
	endfunction
	function automatic chain_t step(input int k);
		chain_t s = scan_chain_pkg::SAFE_CELLS;
		s[188] = 1'h1;
		s[172:165] = 8'h08;
		s[186:177] = (k == 3 || k == 4) ? 10'h123 : (k == 8 || k == 9) ? 10'h143 : 10'h200;
		s[174] = 1'(11'h7bd >> k);
		s[160] = 1'(11'h5ef >> k);
		return s;
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
		logic pa = 1'h1;
		logic pw = 1'h1;
		bq.push_back(r);
		@(posedge aclk);
		{awaddr, wdata, wstrb} <= {a, d, 4'hf};
		{awvalid, wvalid, bready} <= 3'h7;
		while (pa || pw)
		begin
			@(posedge aclk);
			pa = pa && !awready;
			pw = pw && !wready;
			{awvalid, wvalid} <= {pa, pw};
		end
		while (!bvalid)
			@(posedge aclk);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		rq.push_back(e);
		@(posedge aclk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do
			@(posedge aclk);
		while (!arready);
		arvalid <= 1'h0;
		while (!rvalid)
			@(posedge aclk);
		rready <= 1'h0;
	endtask
	task automatic run(input chain_t din, input logic x, input chain_t e, input chain_t m, input chain_t p);
		sq.push_back({m, e & m});
		pq.push_back(pins(p));
		tst.scan(din, x);
	endtask
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, comparator_result, pb0_in} = 8'h01;
		{awaddr, araddr, wdata, wstrb} = 60'h0;
		{port_e_in, port_a_in} = 16'($random(seed));
		occ = 131'(rnd());
		va = rnd();
		vb = rnd();
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		tst.reset_chain();
		rd(12'h000, 34'h0);
		rd(12'h0ff, {2'h2, 32'h0});
		wr(12'h004, 32'h1, 2'h2);
		run(va, 1'h0, cap_of(scan_chain_pkg::SAFE_CELLS), '1, scan_chain_pkg::SAFE_CELLS);
		wr(12'h000, 32'h1, 2'h0);
		rd(12'h000, 34'h1);
		run(vb, 1'h1, cap_of(va), '1, vb);
		repeat (4) @(posedge aclk);
		for (int k = 0; k < 7; k++)
			rd(12'h010 + 12'(4 * k), {2'h0, 32'(vb >> (32 * k))});
		rd(12'h004, {2'h0, 32'h2});
		for (int k = 0; k < 11; k++)
			run(step(k), k > 0, k == 0 ? cap_of(vb) : chain_t'(k == 10) << 193,
				k == 0 ? '1 : (k == 5 || k == 10) ? chain_t'(1) << 193 : '0,
				k == 0 ? scan_chain_pkg::SAFE_CELLS : step(k));
		// The last scan's checks run only after this process yields.
		repeat (2) @(posedge aclk);
		check(sq.size() + pq.size() + rq.size() + bq.size(), 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
